// ==== hdl/ddr2_link_pkg.sv ====
// Constants and types shared by both ends of the DDR2 burst link.
// Assumes both ends run on one system clock of 40 MHz.
package ddr2_link_pkg;
    // System and link clock timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_CK_PERIOD_NS = 200;
    localparam int CK_PERIOD_CYC = LINK_CK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CK_HALF_CYC = CK_PERIOD_CYC / 2;
    localparam int CK_QTR_CYC = CK_PERIOD_CYC / 4;
    localparam logic [2:0] CK_RISE_AT = 3'(CK_PERIOD_CYC - 1);
    localparam logic [2:0] CK_FALL_AT = 3'(CK_HALF_CYC - 1);
    localparam logic [2:0] CK_Q1_AT = 3'(CK_QTR_CYC - 1);
    localparam logic [2:0] CK_Q2_AT = 3'(CK_HALF_CYC + CK_QTR_CYC - 1);
    // Widths of the link.
    localparam int DQ_W = 16;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int PAGE_COLS = 1024;
    // Depth of the posted column command queue, in link clocks.
    localparam int MAX_LAT = 16;
    // Activate to column delay used when no additive latency is set.
    localparam logic [3:0] RCD_CK = 4'h3;
    // Burst length codes and beat counts.
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;
    localparam logic BT_INTERLEAVED = 1'h1;
    // Command encodings on {row strobe, column strobe, write enable}.
    typedef enum logic [2:0] {
        CMD_ACTIVATE = 3'b011,
        CMD_READ = 3'b101,
        CMD_WRITE = 3'b100,
        CMD_NOP = 3'b111
    } cmd_t;
    typedef struct packed {
        logic v;
        logic w;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } slot_t;
endpackage

// ==== hdl/ddr2_link_if.sv ====
// Link between the controller end and the memory device end.
// Two-way pins carry separate value and enable per end; an undriven
// line reads as low.
`timescale 1ns/10ps
interface ddr2_link_if;
    import ddr2_link_pkg::*;
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_dev_o;
    logic [DQ_W-1:0] dq_ctl_o;
    logic [DQ_W-1:0] dq;
    logic dq_dev_oe;
    logic dq_ctl_oe;
    logic dqs_dev_o;
    logic dqs_ctl_o;
    logic dqs_dev_oe;
    logic dqs_ctl_oe;
    logic dqs;
    assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
    assign dqs = dqs_dev_oe ? dqs_dev_o : (dqs_ctl_oe & dqs_ctl_o);
    modport device (
        input ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dqs,
        output dq_dev_o, dq_dev_oe, dqs_dev_o, dqs_dev_oe
    );
    modport controller (
        output ck, cs_n, ras_n, cas_n, we_n, ba, addr,
        output dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe,
        input dq, dqs
    );
endinterface

// ==== hdl/ddr2_ctrl_end.sv ====
// Controller end: makes the link clock, issues activate and column
// commands and moves one burst per request.
// Assumes the device end shares the link interface and mode settings.
`timescale 1ns/10ps
module ddr2_ctrl_end
    import ddr2_link_pkg::*;
#(
    parameter logic [3:0] RCD = RCD_CK
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Mode settings, equal to those given to the device.
    input wire logic [2:0] COL_LAT,
    input wire logic [2:0] ADD_LAT,
    input wire logic [2:0] BURST_LEN_CODE,
    // Request.
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic [BANK_W-1:0] REQ_BANK,
    input wire logic [ADDR_W-1:0] REQ_ROW,
    input wire logic [COL_W-1:0] REQ_COL,
    input wire logic [8*DQ_W-1:0] WDATA,
    // Answer.
    output logic READY,
    output logic [8*DQ_W-1:0] RDATA,
    output logic RDATA_VALID,
    // Memory link.
    ddr2_link_if.controller link
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACT = 2'b01,
        ST_GAP = 2'b10,
        ST_XFER = 2'b11
    } state_t;

    state_t state_reg;
    logic [2:0] div_reg;
    logic ck_reg;
    logic ready_reg, rvalid_reg, wr_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [ADDR_W-1:0] row_reg;
    logic [COL_W-1:0] col_reg;
    logic [8*DQ_W-1:0] wdata_reg, rdata_reg;
    logic [3:0] gap_reg, beat_reg;
    logic [4:0] cyc_reg;
    logic cs_n_reg;
    cmd_t cmd_reg;
    logic [BANK_W-1:0] ba_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DQ_W-1:0] dq_o_reg;
    logic dq_oe_reg, dqs_o_reg, dqs_oe_reg;
    logic [DQ_W:0] in_s1_reg, in_s2_reg;
    logic dqs_s3_reg;

    logic rise_evt, fall_evt, q_evt, dqs_edge, wr_done, rd_done, col_go;
    logic [3:0] wl, bl_beats;
    logic [DQ_W-1:0] dq_s;

    assign rise_evt = div_reg == CK_RISE_AT;
    assign fall_evt = div_reg == CK_FALL_AT;
    assign q_evt = (div_reg == CK_Q1_AT) || (div_reg == CK_Q2_AT);
    assign wl = 4'(ADD_LAT) + 4'(COL_LAT) - 4'h1;
    assign bl_beats = (BURST_LEN_CODE == BL_CODE_8) ? BEATS_8 : BEATS_4;
    assign dq_s = in_s2_reg[DQ_W:1];
    assign dqs_edge = in_s2_reg[0] ^ dqs_s3_reg;
    assign col_go = (state_reg == ST_GAP) && fall_evt && (gap_reg <= 4'h1);
    assign wr_done = (state_reg == ST_XFER) && wr_reg && q_evt && dq_oe_reg
        && (beat_reg == bl_beats);
    assign rd_done = (state_reg == ST_XFER) && !wr_reg && dqs_edge
        && (beat_reg == bl_beats - 4'h1);

    // The link clock is divided down from the system clock.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div_reg <= 3'h0;
            ck_reg <= 1'b0;
        end else begin
            div_reg <= rise_evt ? 3'h0 : div_reg + 3'h1;
            if (rise_evt) begin
                ck_reg <= 1'b1;
            end else if (fall_evt) begin
                ck_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
            dqs_s3_reg <= 1'b0;
        end else begin
            in_s1_reg <= {link.dq, link.dqs};
            in_s2_reg <= in_s1_reg;
            dqs_s3_reg <= in_s2_reg[0];
        end
    end

    // One burst at a time, never interrupted, so column commands are
    // always far more than two clocks apart.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
            wr_reg <= 1'b0;
            bank_reg <= '0;
            row_reg <= '0;
            col_reg <= '0;
            wdata_reg <= '0;
            gap_reg <= 4'h0;
            cyc_reg <= 5'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (REQ) begin
                    state_reg <= ST_ACT;
                    ready_reg <= 1'b0;
                    wr_reg <= REQ_WRITE;
                    bank_reg <= REQ_BANK;
                    row_reg <= REQ_ROW;
                    col_reg <= REQ_COL;
                    wdata_reg <= WDATA;
                end
                ST_ACT: if (fall_evt) begin
                    state_reg <= ST_GAP;
                    gap_reg <= (ADD_LAT == 3'h0) ? RCD : 4'h1;
                end
                ST_GAP: if (col_go) begin
                    state_reg <= ST_XFER;
                    cyc_reg <= 5'h1f;
                end else if (fall_evt) begin
                    gap_reg <= gap_reg - 4'h1;
                end
                ST_XFER: begin
                    if (rise_evt) begin
                        cyc_reg <= cyc_reg + 5'h1;
                    end
                    if (wr_done || rd_done) begin
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Command pins change on the falling link edge; with no precharge
    // ever issued, write recovery before precharge holds trivially.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cs_n_reg <= 1'b1;
            cmd_reg <= CMD_NOP;
            ba_reg <= '0;
            addr_reg <= '0;
        end else if (fall_evt) begin
            cs_n_reg <= 1'b0;
            cmd_reg <= CMD_NOP;
            if (state_reg == ST_ACT) begin
                cmd_reg <= CMD_ACTIVATE;
                ba_reg <= bank_reg;
                addr_reg <= row_reg;
            end else if (col_go) begin
                cmd_reg <= wr_reg ? CMD_WRITE : CMD_READ;
                ba_reg <= bank_reg;
                addr_reg <= {{(ADDR_W-COL_W){1'b0}}, col_reg};
            end
        end
    end

    // Write strobe: preamble half a clock before the write latency,
    // then one beat per strobe edge, a quarter clock after each link edge.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dq_o_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
            beat_reg <= 4'h0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd_done;
            if (col_go) begin
                beat_reg <= 4'h0;
            end else if (state_reg == ST_XFER && wr_reg) begin
                if (wr_done) begin
                    dq_oe_reg <= 1'b0;
                    dqs_oe_reg <= 1'b0;
                    dqs_o_reg <= 1'b0;
                end else if (fall_evt && cyc_reg == {1'b0, wl - 4'h1}) begin
                    dqs_oe_reg <= 1'b1;
                    dqs_o_reg <= 1'b0;
                end else if (q_evt && dqs_oe_reg && cyc_reg >= {1'b0, wl}
                        && beat_reg != bl_beats) begin
                    dq_oe_reg <= 1'b1;
                    dq_o_reg <= wdata_reg[DQ_W*beat_reg +: DQ_W];
                    dqs_o_reg <= ~dqs_o_reg;
                    beat_reg <= beat_reg + 4'h1;
                end
            end else if (state_reg == ST_XFER && dqs_edge) begin
                rdata_reg[DQ_W*beat_reg +: DQ_W] <= dq_s;
                beat_reg <= beat_reg + 4'h1;
            end
        end
    end

    assign READY = ready_reg;
    assign RDATA = rdata_reg;
    assign RDATA_VALID = rvalid_reg;
    assign link.ck = ck_reg;
    assign link.cs_n = cs_n_reg;
    assign {link.ras_n, link.cas_n, link.we_n} = cmd_reg;
    assign link.ba = ba_reg;
    assign link.addr = addr_reg;
    assign link.dq_ctl_o = dq_o_reg;
    assign link.dq_ctl_oe = dq_oe_reg;
    assign link.dqs_ctl_o = dqs_o_reg;
    assign link.dqs_ctl_oe = dqs_oe_reg;
endmodule

// ==== hdl/ddr2_device_end.sv ====
// Memory device end: decodes commands, posts column commands for the full
// additive plus column latency (less one for writes) and runs read and write bursts over one page.
// Assumes the controller makes the link clock; all link pins are
// synchronised into the system clock before use.
//
// Overview of operation
// - No-operation command does nothing at all.
// - Chip select high disables the command decoder.
// - Page holds 1024 columns, ten address bits.
// - Burst wraps inside its aligned column group.
// - Controller never interrupts bursts except same type.
// - Column commands at least two clocks apart.
// - Column command accepted early, held additive latency.
// - Early column commands need nonzero additive latency.
// - Read latency is additive plus column latency.
// - Write latency is read latency minus one.
// - Write latency counts from command to strobe.
// - Only lengths four and eight, two orders.
// - Sequential order counts within nibble, wraps.
// - Interleaved order is start XOR beat.
// - No burst terminate command exists.
// - First read word after read latency clocks.
// - Strobe preamble low, data on strobe edges.
// - Controller drives write preamble and centred beats.
// - Extra write data after the burst ignored.
// - Write recovery passes before precharging the bank.
// - Interrupting command comes exactly two clocks later.
// - Write to precharge spans latency, burst, recovery.
`timescale 1ns/10ps
module ddr2_device_end
    import ddr2_link_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Mode settings.
    input wire logic [2:0] COL_LAT,
    input wire logic [2:0] ADD_LAT,
    input wire logic [2:0] BURST_LEN_CODE,
    input wire logic BURST_TYPE,
    // Status.
    output logic READ_ACTIVE,
    output logic WRITE_ACTIVE,
    // Memory link.
    ddr2_link_if.device link
);
    localparam int PIN_W = 5 + BANK_W + ADDR_W + DQ_W + 1;
    localparam int MEM_W = BANK_W + COL_W;

    // Synchronised pins: ck, cs_n, command, bank, address, data, strobe.
    logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg;
    logic ck_s3_reg, dqs_s3_reg;
    logic ck_s, cs_n_s, dqs_s;
    cmd_t cmd_s;
    logic [BANK_W-1:0] ba_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DQ_W-1:0] dq_s;
    logic ck_rise, ck_edge, dqs_edge;

    logic [3:0] rl, wl, bl_beats, ins_idx;
    logic bl8, ilv, col_cmd;
    slot_t new_slot;
    slot_t slot_reg [MAX_LAT];
    logic rd_start, wr_start, rd_pre;

    logic [DQ_W-1:0] mem [2**MEM_W];
    logic rd_on_reg, wr_on_reg;
    logic [3:0] rd_beat_reg, wr_beat_reg;
    logic [BANK_W-1:0] rd_bank_reg, wr_bank_reg;
    logic [COL_W-1:0] rd_col_reg, wr_col_reg;
    logic [DQ_W-1:0] dq_o_reg;
    logic dq_oe_reg, dqs_o_reg, dqs_oe_reg;

    // Column of a beat: the low two bits (three for length eight) are reordered, the upper
    // bits stay, so a burst never leaves its aligned group.
    function automatic logic [COL_W-1:0] beat_col(
        input logic [COL_W-1:0] start,
        input logic [3:0] beat,
        input logic len8,
        input logic inter
    );
        logic [1:0] lo;
        logic hi;
        lo = inter ? (start[1:0] ^ beat[1:0])
                   : 2'(start[1:0] + beat[1:0]);
        hi = start[2] ^ (len8 & beat[2]);
        return {start[COL_W-1:3], hi, lo};
    endfunction

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            ck_s3_reg <= 1'b0;
            dqs_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {link.ck, link.cs_n, link.ras_n, link.cas_n,
                link.we_n, link.ba, link.addr, link.dq, link.dqs};
            pin_s2_reg <= pin_s1_reg;
            ck_s3_reg <= ck_s;
            dqs_s3_reg <= dqs_s;
        end
    end

    assign {ck_s, cs_n_s, cmd_s, ba_s, addr_s, dq_s, dqs_s} = pin_s2_reg;
    assign ck_rise = ck_s & ~ck_s3_reg;
    assign ck_edge = ck_s ^ ck_s3_reg;
    assign dqs_edge = dqs_s ^ dqs_s3_reg;

    assign rl = 4'(ADD_LAT) + 4'(COL_LAT);
    assign wl = rl - 4'h1;
    // Unknown length codes fall back to four beats.
    assign bl8 = BURST_LEN_CODE == BL_CODE_8;
    assign bl_beats = bl8 ? BEATS_8 : BEATS_4;
    assign ilv = BURST_TYPE == BT_INTERLEAVED;

    // Only read and write reach the queue; no-operation, deselect and
    // the old burst-stop pattern fall through untouched.
    assign col_cmd = !cs_n_s
        && (cmd_s == CMD_READ || cmd_s == CMD_WRITE);
    assign ins_idx = (cmd_s == CMD_WRITE) ? wl - 4'h1 : rl - 4'h1;
    assign new_slot = '{v: 1'b1, w: cmd_s == CMD_WRITE, bank: ba_s,
        col: addr_s[COL_W-1:0]};

    // Each entry starts its burst on the rise that shifts it out of slot zero; activation
    // state is not checked, so early column commands are simply held.
    for (genvar k = 0; k < MAX_LAT; k++) begin : g_slot
        always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                slot_reg[k] <= '0;
            end else if (ck_rise) begin
                if (col_cmd && ins_idx == 4'(k)) begin
                    slot_reg[k] <= new_slot;
                end else if (k == MAX_LAT - 1) begin
                    slot_reg[k] <= '0;
                end else begin
                    slot_reg[k] <= slot_reg[(k + 1) % MAX_LAT];
                end
            end
        end
    end

    assign rd_start = ck_rise && slot_reg[0].v && !slot_reg[0].w;
    assign wr_start = ck_rise && slot_reg[0].v && slot_reg[0].w;
    assign rd_pre = ck_rise && slot_reg[1].v && !slot_reg[1].w;

    // Read data leaves edge aligned with the strobe, one beat per link
    // edge. A new read start restarts the burst, which is how a same
    // type interruption two clocks later takes effect.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_on_reg <= 1'b0;
            rd_beat_reg <= 4'h0;
            rd_bank_reg <= '0;
            rd_col_reg <= '0;
            dq_o_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
        end else if (rd_start) begin
            rd_on_reg <= 1'b1;
            rd_beat_reg <= 4'h1;
            rd_bank_reg <= slot_reg[0].bank;
            rd_col_reg <= slot_reg[0].col;
            dq_o_reg <= mem[{slot_reg[0].bank,
                beat_col(slot_reg[0].col, 4'h0, bl8, ilv)}];
            dq_oe_reg <= 1'b1;
            dqs_o_reg <= 1'b1;
            dqs_oe_reg <= 1'b1;
        end else if (ck_edge && rd_on_reg) begin
            if (rd_beat_reg == bl_beats) begin
                rd_on_reg <= 1'b0;
                dq_oe_reg <= 1'b0;
                dqs_o_reg <= 1'b0;
                // Keep the strobe low if a seamless read follows.
                dqs_oe_reg <= rd_pre;
            end else begin
                dq_o_reg <= mem[{rd_bank_reg,
                    beat_col(rd_col_reg, rd_beat_reg, bl8, ilv)}];
                dqs_o_reg <= ~dqs_o_reg;
                rd_beat_reg <= rd_beat_reg + 4'h1;
            end
        end else if (rd_pre) begin
            dqs_oe_reg <= 1'b1;
            dqs_o_reg <= 1'b0;
        end
    end

    // Write beats are taken on strobe edges from the write latency on;
    // once the programmed count is in, the data lines are ignored.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wr_on_reg <= 1'b0;
            wr_beat_reg <= 4'h0;
            wr_bank_reg <= '0;
            wr_col_reg <= '0;
        end else if (wr_start) begin
            wr_on_reg <= 1'b1;
            wr_beat_reg <= 4'h0;
            wr_bank_reg <= slot_reg[0].bank;
            wr_col_reg <= slot_reg[0].col;
        end else if (dqs_edge && wr_on_reg) begin
            wr_beat_reg <= wr_beat_reg + 4'h1;
            if (wr_beat_reg == bl_beats - 4'h1) begin
                wr_on_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (dqs_edge && wr_on_reg && !wr_start) begin
            mem[{wr_bank_reg, beat_col(wr_col_reg, wr_beat_reg, bl8, ilv)}]
                <= dq_s;
        end
    end

    assign READ_ACTIVE = rd_on_reg;
    assign WRITE_ACTIVE = wr_on_reg;
    assign link.dq_dev_o = dq_o_reg;
    assign link.dq_dev_oe = dq_oe_reg;
    assign link.dqs_dev_o = dqs_o_reg;
    assign link.dqs_dev_oe = dqs_oe_reg;
endmodule

// ==== tb/ddr2_link_properties.sv ====
// Concurrent checks on the link joining the controller and device ends.
// Assumes every input comes straight from the link interface signals.
`timescale 1ns/10ps
module ddr2_link_properties
    import ddr2_link_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Link signals.
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [DQ_W-1:0] dq_dev_o,
    input wire logic dq_dev_oe,
    input wire logic dqs_dev_o,
    input wire logic dqs_dev_oe,
    input wire logic dq_ctl_oe,
    input wire logic dqs_ctl_o,
    input wire logic dqs_ctl_oe
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic ck_q;
    logic ck_rise;
    logic col_rise;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST)
            ck_q <= 1'b0;
        else
            ck_q <= ck;
    end
    assign ck_rise = ck && !ck_q && !cs_n;
    assign col_rise = ck_rise && ras_n && !cas_n;
    // A link clock rise comes every 8 CLK, so 15 quiet cycles span two link clocks.
    a_column_gap: assert property (col_rise |=> (!col_rise)[*8] ##1 (!col_rise)[*7])
        else $error("column commands closer than two link clocks");
    a_command_set: assert property (ck_rise |->
        {ras_n, cas_n, we_n} inside {CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_NOP})
        else $error("unexpected command on the link");
    // Leaving deselect after reset comes at the first fall, before any rise of the clock.
    a_command_at_fall: assert property ($changed({cs_n, ras_n, cas_n, we_n})
        |-> !ck && (ck_q || $past(cs_n)))
        else $error("command pins changed away from a link clock fall");
    a_read_preamble: assert property ($rose(dqs_dev_oe) |->
        !dqs_dev_o ##1 (!dqs_dev_o && !dq_dev_oe)[*3])
        else $error("read strobe preamble missing");
    a_read_first_edge: assert property ($rose(dq_dev_oe) |->
        dqs_dev_o && dqs_dev_oe && $past(dqs_dev_oe, 4))
        else $error("first read word not on a rising strobe");
    a_read_beat_hold: assert property ($rose(dq_dev_oe) |=>
        ($stable(dq_dev_o) && dq_dev_oe)[*3])
        else $error("read word did not stand half a link clock");
    a_read_beat_edge: assert property (dq_dev_oe && $past(dq_dev_oe)
        && $changed(dq_dev_o) |-> $changed(dqs_dev_o))
        else $error("read word changed without a strobe edge");
    a_write_preamble: assert property ($rose(dq_ctl_oe) |->
        $rose(dqs_ctl_o) && $past(dqs_ctl_oe, 4))
        else $error("write strobe preamble missing");
    a_one_talker: assert property (!(dq_dev_oe && dq_ctl_oe))
        else $error("both ends drive the data lines");
    cover property (col_rise && !we_n);
    cover property ($rose(dq_ctl_oe));
    cover property ($rose(dq_dev_oe));
endmodule

// ==== tb/ddr2_burst_access_logic_tb.sv ====
// Self-checking bench: controller end and device end joined by the link.
// Assumes the link clock comes from the controller end's divider.
`timescale 1ns/10ps
module ddr2_burst_access_logic_tb;
    import ddr2_link_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] col_lat = 3'h3;
    logic [2:0] add_lat = 3'h2;
    logic [2:0] bl_code = BL_CODE_4;
    logic burst_type = 1'b0;
    logic req = 1'b0;
    logic req_write = 1'b0;
    logic [BANK_W-1:0] req_bank = '0;
    logic [ADDR_W-1:0] req_row = '0;
    logic [COL_W-1:0] req_col = '0;
    logic [8*DQ_W-1:0] wdata = '0;
    logic ready;
    logic [8*DQ_W-1:0] rdata;
    logic rdata_valid;
    logic read_active;
    logic write_active;
    logic [7:0] lat_cnt = 8'h0;
    logic [7:0] lat_seen = 8'h0;
    logic oe_q = 1'b0;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    ddr2_link_if ddr2_link_if_inst ();
    ddr2_ctrl_end ddr2_ctrl_end_inst (.CLK(clk), .NRST(nrst), .COL_LAT(col_lat),
        .ADD_LAT(add_lat), .BURST_LEN_CODE(bl_code), .REQ(req), .REQ_WRITE(req_write),
        .REQ_BANK(req_bank), .REQ_ROW(req_row), .REQ_COL(req_col), .WDATA(wdata),
        .READY(ready), .RDATA(rdata), .RDATA_VALID(rdata_valid), .link(ddr2_link_if_inst));
    ddr2_device_end ddr2_device_end_inst (.CLK(clk), .NRST(nrst), .COL_LAT(col_lat),
        .ADD_LAT(add_lat), .BURST_LEN_CODE(bl_code), .BURST_TYPE(burst_type),
        .READ_ACTIVE(read_active), .WRITE_ACTIVE(write_active), .link(ddr2_link_if_inst));
    ddr2_link_properties ddr2_link_properties_inst (.CLK(clk), .NRST(nrst),
        .ck(ddr2_link_if_inst.ck), .cs_n(ddr2_link_if_inst.cs_n),
        .ras_n(ddr2_link_if_inst.ras_n), .cas_n(ddr2_link_if_inst.cas_n),
        .we_n(ddr2_link_if_inst.we_n), .dq_dev_o(ddr2_link_if_inst.dq_dev_o),
        .dq_dev_oe(ddr2_link_if_inst.dq_dev_oe), .dqs_dev_o(ddr2_link_if_inst.dqs_dev_o),
        .dqs_dev_oe(ddr2_link_if_inst.dqs_dev_oe), .dq_ctl_oe(ddr2_link_if_inst.dq_ctl_oe),
        .dqs_ctl_o(ddr2_link_if_inst.dqs_ctl_o), .dqs_ctl_oe(ddr2_link_if_inst.dqs_ctl_oe));
    wire col_cmd = !ddr2_link_if_inst.cs_n && ddr2_link_if_inst.ras_n && !ddr2_link_if_inst.cas_n;
    wire oe_any = ddr2_link_if_inst.dq_dev_oe | ddr2_link_if_inst.dq_ctl_oe;
    always #12.5 clk = ~clk;
    // Link clock rises since the last column command; latched when data first moves.
    always @(posedge ddr2_link_if_inst.ck) lat_cnt <= col_cmd ? 8'h0 : lat_cnt + 8'h1;
    always @(posedge clk) begin
        oe_q <= oe_any;
        if (oe_any && !oe_q)
            lat_seen <= lat_cnt;
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [2:0] off(input logic [2:0] s, input logic [2:0] b,
        input logic len8, input logic inter);
        logic [1:0] lo;
        lo = inter ? (s[1:0] ^ b[1:0]) : (s[1:0] + b[1:0]);
        return {s[2] ^ (len8 & b[2]), lo};
    endfunction
    task automatic xfer(input logic w, input logic [COL_W-1:0] col);
        logic got;
        logic act;
        logic [7:0] rl;
        got = 1'b0;
        act = 1'b0;
        rl = 8'(add_lat) + 8'(col_lat);
        @(posedge clk);
        req <= 1'b1;
        req_write <= w;
        req_col <= col;
        @(posedge clk);
        req <= 1'b0;
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk);
            #1;
            got |= (rdata_valid === 1'b1);
            act |= ((w ? write_active : read_active) === 1'b1);
            if (ready === 1'b1)
                break;
        end
        chk("ready", ready, 1'b1);
        chk("read pulse", got, !w);
        chk("burst active", act, 1'b1);
        chk("latency", lat_seen, w ? rl - 8'h1 : rl);
    endtask
    initial begin
        // Each pass changes the static mode inputs under reset, then writes a
        // group at the page top and reads it back from each nonzero start offset in the burst.
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            nrst <= 1'b0;
            bl_code <= c[1] ? BL_CODE_8 : BL_CODE_4;
            burst_type <= c[0];
            add_lat <= 3'(c == 1 ? 0 : c + 1);
            col_lat <= 3'(3 + c[0]);
            req_bank <= 3'(c);
            req_row <= 13'(c);
            for (int k = 0; k < 8; k++)
                wdata[16*k +: 16] <= 16'h5a00 + 16'(c * 16 + k);
            repeat (20) @(posedge clk);
            nrst <= 1'b1;
            xfer(1'b1, 10'h3f8);
            for (int s = 1; s < 8; s++) begin
                if (!c[1] && s[2])
                    continue;
                xfer(1'b0, 10'h3f8 | 10'(s));
                for (int b = 0; b < (c[1] ? 8 : 4); b++)
                    chk("beat", rdata[16*b +: 16], wdata[16*off(3'(s), 3'(b), c[1], c[0]) +: 16]);
            end
        end
        results();
    end
endmodule
